// file: uae_top.sv
`timescale 1ns/100ps
`default_nettype none
// Functional notes
// - With its clock stopped every register and the serial output hold.
// - With the clock running the block transmits and receives normally.
// - Transmit and receive enables reach the serial logic only on base clock ticks; transmit enable gates the byte queue at once.
// - Power and receive enable with a low input starts a reception.
module uae_top #(
	parameter int DIV_W = 8
) (
	input  wire logic        clk,
	input  wire logic        rst,
	input  wire logic [7:0]  addr,
	input  wire logic [31:0] wdata,
	input  wire logic        wr,
	input  wire logic        rd,
	output var  logic [31:0] rdata,
	input  wire logic        serial_in_pin,
	output var  logic        serial_out_pin,
	output var  logic        irq
);
	import uae_pkg::*;

	if (DIV_W < 1 || DIV_W > 16) begin : g_chk
		$error("DIV_W must be between 1 and 16");
	end

	typedef enum logic [3:0] {
		TX_IDLE  = 4'h1,
		TX_START = 4'h2,
		TX_DATA  = 4'h4,
		TX_STOP  = 4'h8
	} uae_tx_state_t;

	uae_link_if lnk ();

	////////////////////////////////////////////////////////////////////////
	// Register file

	logic              uart_power_on;
	logic              next_uart_power_on;
	logic              tx_enable_bit;
	logic              next_tx_enable_bit;
	logic              rx_enable_bit;
	logic              next_rx_enable_bit;
	logic [DIV_W-1:0]  baud_gen_ctrl;
	logic [DIV_W-1:0]  next_baud_gen_ctrl;
	logic [7:0]        tx_shift_reg;
	logic [7:0]        next_tx_shift_reg;
	logic              tx_pend;
	logic              next_tx_pend;
	logic [7:0]        rx_hold;
	logic [7:0]        next_rx_hold;
	logic [STAT_W-1:0] stat;
	logic [STAT_W-1:0] next_stat;
	logic [STAT_W-1:0] mask;
	logic [STAT_W-1:0] next_mask;
	logic [31:0]       next_rdata;
	logic              next_irq;
	logic              tx_done_irq;
	logic              tx_busy;

	always_comb begin
		next_uart_power_on = uart_power_on;
		next_tx_enable_bit = tx_enable_bit;
		next_rx_enable_bit = rx_enable_bit;
		next_baud_gen_ctrl = baud_gen_ctrl;
		next_tx_shift_reg = tx_shift_reg;
		next_tx_pend = tx_pend;
		next_rx_hold = rx_hold;
		next_mask = mask;
		next_stat = stat;
		next_rdata = 32'h0000_0000;
		if (wr) begin
			case (addr)
				ADDR_CTRL: begin
					next_uart_power_on = wdata[CTRL_POWER];
					next_tx_enable_bit = wdata[CTRL_TX_EN];
					next_rx_enable_bit = wdata[CTRL_RX_EN];
				end
				ADDR_BAUD: next_baud_gen_ctrl = wdata[DIV_W-1:0];
				ADDR_TX: begin
					// A byte written while one is queued or sending is dropped
					if (!tx_pend && !tx_busy) begin
						next_tx_shift_reg = wdata[7:0];
						next_tx_pend = 1'b1;
					end
				end
				ADDR_STAT: next_stat = stat & ~wdata[STAT_W-1:0];
				ADDR_MASK: next_mask = wdata[STAT_W-1:0];
				default: ;
			endcase
		end
		if (tx_busy)
			next_tx_pend = 1'b0;
		// Set wins over a clear in the same cycle
		if (tx_done_irq)
			next_stat[STAT_TX_DONE] = 1'b1;
		if (lnk.rx_done) begin
			next_stat[STAT_RX_DONE] = 1'b1;
			next_rx_hold = lnk.rx_data;
		end
		if (!uart_power_on || !tx_enable_bit)
			next_tx_pend = 1'b0;
		if (!uart_power_on)
			next_stat = '0;
		if (rd) begin
			case (addr)
				ADDR_CTRL: begin
					next_rdata[CTRL_POWER] = uart_power_on;
					next_rdata[CTRL_TX_EN] = tx_enable_bit;
					next_rdata[CTRL_RX_EN] = rx_enable_bit;
					next_rdata[CTRL_TX_BUSY] = tx_busy | tx_pend;
					next_rdata[CTRL_RX_BUSY] = lnk.rx_busy;
				end
				ADDR_BAUD: next_rdata[DIV_W-1:0] = baud_gen_ctrl;
				ADDR_TX:   next_rdata[7:0] = tx_shift_reg;
				ADDR_RX:   next_rdata[7:0] = rx_hold;
				ADDR_STAT: next_rdata[STAT_W-1:0] = stat;
				ADDR_MASK: next_rdata[STAT_W-1:0] = mask;
				default: ;
			endcase
		end
		next_irq = |(next_stat & next_mask);
	end

	// Nothing here keeps running without clk: a stopped clock freezes all
	// state and the output pin, which is exactly the retention wanted.
	always_ff @(posedge clk) begin
		if (rst) begin
			uart_power_on <= 1'b0;
			tx_enable_bit <= 1'b0;
			rx_enable_bit <= 1'b0;
			baud_gen_ctrl <= DIV_W'(BAUD_DIV_RST);
			tx_shift_reg <= 8'h00;
			tx_pend <= 1'b0;
			rx_hold <= 8'h00;
			stat <= '0;
			mask <= MASK_RST;
			rdata <= 32'h0000_0000;
			irq <= 1'b0;
		end else begin
			uart_power_on <= next_uart_power_on;
			tx_enable_bit <= next_tx_enable_bit;
			rx_enable_bit <= next_rx_enable_bit;
			baud_gen_ctrl <= next_baud_gen_ctrl;
			tx_shift_reg <= next_tx_shift_reg;
			tx_pend <= next_tx_pend;
			rx_hold <= next_rx_hold;
			stat <= next_stat;
			mask <= next_mask;
			rdata <= next_rdata;
			irq <= next_irq;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Base clock and enable synchronisation

	logic [DIV_W-1:0] div_cnt;
	logic [DIV_W-1:0] next_div_cnt;
	logic             base_tick;
	logic             next_base_tick;
	logic             tx_en_s;
	logic             next_tx_en_s;
	logic             rx_en_s;
	logic             next_rx_en_s;

	always_comb begin
		next_div_cnt = div_cnt + 1'b1;
		next_base_tick = 1'b0;
		next_tx_en_s = tx_en_s;
		next_rx_en_s = rx_en_s;
		if (div_cnt >= baud_gen_ctrl) begin
			next_div_cnt = '0;
			next_base_tick = 1'b1;
		end
		// Enables only move on a base tick or at power off, so a fast off/on toggle can be
		// missed entirely; that is why software must space them.
		if (base_tick) begin
			next_tx_en_s = tx_enable_bit;
			next_rx_en_s = rx_enable_bit;
		end
		if (!uart_power_on) begin
			next_div_cnt = '0;
			next_base_tick = 1'b0;
			next_tx_en_s = 1'b0;
			next_rx_en_s = 1'b0;
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			div_cnt <= '0;
			base_tick <= 1'b0;
			tx_en_s <= 1'b0;
			rx_en_s <= 1'b0;
		end else begin
			div_cnt <= next_div_cnt;
			base_tick <= next_base_tick;
			tx_en_s <= next_tx_en_s;
			rx_en_s <= next_rx_en_s;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Transmitter

	uae_tx_state_t     tx_state;
	uae_tx_state_t     next_tx_state;
	logic [TICK_W-1:0] tx_tick;
	logic [TICK_W-1:0] next_tx_tick;
	logic [BIT_W-1:0]  tx_bit;
	logic [BIT_W-1:0]  next_tx_bit;
	logic [7:0]        tx_sh;
	logic [7:0]        next_tx_sh;
	logic              next_serial_out_pin;
	logic              next_tx_done_irq;

	assign tx_busy = (tx_state != TX_IDLE);

	always_comb begin
		next_tx_state = tx_state;
		next_tx_tick = tx_tick;
		next_tx_bit = tx_bit;
		next_tx_sh = tx_sh;
		next_serial_out_pin = serial_out_pin;
		next_tx_done_irq = 1'b0;
		if (!uart_power_on || !tx_en_s) begin
			next_tx_state = TX_IDLE;
			next_tx_tick = '0;
			next_serial_out_pin = 1'b1;
		end else if (base_tick) begin
			next_tx_tick = tx_tick + 1'b1;
			case (tx_state)
				TX_IDLE: begin
					next_tx_tick = '0;
					if (tx_pend) begin
						next_tx_sh = tx_shift_reg;
						next_serial_out_pin = 1'b0;
						next_tx_state = TX_START;
					end
				end
				TX_START: begin
					if (tick_last(tx_tick, BIT_TICKS)) begin
						next_tx_tick = '0;
						next_tx_bit = '0;
						next_serial_out_pin = tx_sh[0];
						next_tx_sh = {1'b0, tx_sh[7:1]};
						next_tx_state = TX_DATA;
					end
				end
				TX_DATA: begin
					if (tick_last(tx_tick, BIT_TICKS)) begin
						next_tx_tick = '0;
						next_tx_bit = tx_bit + 1'b1;
						next_serial_out_pin = tx_sh[0];
						next_tx_sh = {1'b0, tx_sh[7:1]};
						if (tx_bit == BIT_W'(DATA_BITS - 1)) begin
							next_serial_out_pin = 1'b1;
							next_tx_state = TX_STOP;
						end
					end
				end
				TX_STOP: begin
					if (tick_last(tx_tick, BIT_TICKS)) begin
						next_tx_tick = '0;
						// Only now may the next byte be accepted
						next_tx_done_irq = 1'b1;
						next_tx_state = TX_IDLE;
					end
				end
				default: next_tx_state = TX_IDLE;
			endcase
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			tx_state <= TX_IDLE;
			tx_tick <= '0;
			tx_bit <= '0;
			tx_sh <= 8'h00;
			serial_out_pin <= 1'b1;
			tx_done_irq <= 1'b0;
		end else begin
			tx_state <= next_tx_state;
			tx_tick <= next_tx_tick;
			tx_bit <= next_tx_bit;
			tx_sh <= next_tx_sh;
			serial_out_pin <= next_serial_out_pin;
			tx_done_irq <= next_tx_done_irq;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Receiver

	assign lnk.base_tick = base_tick;
	assign lnk.rx_run = uart_power_on & rx_en_s;
	assign lnk.serial_in = serial_in_pin;

	uae_rx u_rx (
		.clk (clk),
		.rst (rst),
		.lnk (lnk.rcv)
	);
endmodule
`default_nettype wire

// file: uae_pkg.sv
`default_nettype none
package uae_pkg;
	// Register byte addresses on the plain register port
	localparam logic [7:0] ADDR_CTRL = 8'h00;
	localparam logic [7:0] ADDR_BAUD = 8'h04;
	localparam logic [7:0] ADDR_TX   = 8'h08;
	localparam logic [7:0] ADDR_RX   = 8'h0c;
	localparam logic [7:0] ADDR_STAT = 8'h10;
	localparam logic [7:0] ADDR_MASK = 8'h14;

	// Control register fields
	localparam int CTRL_POWER   = 0;
	localparam int CTRL_TX_EN   = 1;
	localparam int CTRL_RX_EN   = 2;
	localparam int CTRL_TX_BUSY = 3;
	localparam int CTRL_RX_BUSY = 4;

	// Status and mask fields
	localparam int STAT_TX_DONE = 0;
	localparam int STAT_RX_DONE = 1;
	localparam int STAT_W       = 2;

	// Reset values
	localparam int BAUD_DIV_RST = 9;
	localparam logic [STAT_W-1:0] MASK_RST = 2'h0;

	// Base clock ticks per serial bit, and the mid-bit sample point
	localparam int BIT_TICKS = 16;
	localparam int HALF_TICKS = BIT_TICKS / 2;
	localparam int TICK_W = $clog2(BIT_TICKS);
	localparam int DATA_BITS = 8;
	localparam int BIT_W = $clog2(DATA_BITS);

	function automatic logic tick_last(input logic [TICK_W-1:0] cnt,
		input int lim);
		tick_last = (cnt == TICK_W'(lim - 1));
	endfunction
endpackage
`default_nettype wire

// file: uae_link_if.sv
`timescale 1ns/100ps
`default_nettype none
interface uae_link_if;
	logic       base_tick;
	logic       rx_run;
	logic       serial_in;
	logic [7:0] rx_data;
	logic       rx_done;
	logic       rx_busy;

	modport ctl (
		output base_tick,
		output rx_run,
		output serial_in,
		input  rx_data,
		input  rx_done,
		input  rx_busy
	);
	modport rcv (
		input  base_tick,
		input  rx_run,
		input  serial_in,
		output rx_data,
		output rx_done,
		output rx_busy
	);
endinterface
`default_nettype wire

// file: uae_rx.sv
`timescale 1ns/100ps
`default_nettype none
module uae_rx (
	input  wire logic clk,
	input  wire logic rst,
	uae_link_if.rcv   lnk
);
	import uae_pkg::*;

	typedef enum logic [3:0] {
		RX_IDLE  = 4'h1,
		RX_START = 4'h2,
		RX_DATA  = 4'h4,
		RX_STOP  = 4'h8
	} uae_rx_state_t;

	uae_rx_state_t     state;
	uae_rx_state_t     next_state;
	logic [TICK_W-1:0] tick_cnt;
	logic [TICK_W-1:0] next_tick_cnt;
	logic [BIT_W-1:0]  bit_cnt;
	logic [BIT_W-1:0]  next_bit_cnt;
	logic [7:0]        shift;
	logic [7:0]        next_shift;
	logic              done;
	logic              next_done;

	always_comb begin
		next_state = state;
		next_tick_cnt = tick_cnt;
		next_bit_cnt = bit_cnt;
		next_shift = shift;
		next_done = 1'b0;
		if (!lnk.rx_run) begin
			// Power off or receive disabled: receiver back to idle
			next_state = RX_IDLE;
			next_tick_cnt = '0;
			next_bit_cnt = '0;
		end else if (lnk.base_tick) begin
			next_tick_cnt = tick_cnt + 1'b1;
			case (state)
				RX_IDLE: begin
					next_tick_cnt = '0;
					// A low line with receive running counts as a start bit
					if (!lnk.serial_in)
						next_state = RX_START;
				end
				RX_START: begin
					if (tick_last(tick_cnt, HALF_TICKS)) begin
						next_tick_cnt = '0;
						next_bit_cnt = '0;
						// Glitch shorter than half a bit is dropped
						next_state = lnk.serial_in ? RX_IDLE : RX_DATA;
					end
				end
				RX_DATA: begin
					if (tick_last(tick_cnt, BIT_TICKS)) begin
						next_tick_cnt = '0;
						next_shift = {lnk.serial_in, shift[7:1]};
						next_bit_cnt = bit_cnt + 1'b1;
						if (bit_cnt == BIT_W'(DATA_BITS - 1))
							next_state = RX_STOP;
					end
				end
				RX_STOP: begin
					if (tick_last(tick_cnt, BIT_TICKS)) begin
						next_tick_cnt = '0;
						next_done = 1'b1;
						next_state = RX_IDLE;
					end
				end
				default: next_state = RX_IDLE;
			endcase
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			state <= RX_IDLE;
			tick_cnt <= '0;
			bit_cnt <= '0;
			shift <= 8'h00;
			done <= 1'b0;
		end else begin
			state <= next_state;
			tick_cnt <= next_tick_cnt;
			bit_cnt <= next_bit_cnt;
			shift <= next_shift;
			done <= next_done;
		end
	end

	assign lnk.rx_data = shift;
	assign lnk.rx_done = done;
	assign lnk.rx_busy = (state != RX_IDLE);
endmodule
`default_nettype wire

// file: uae_props.sv
`timescale 1ns/100ps
`default_nettype none
module uae_props
	import uae_pkg::*;
(
	input wire logic        clk,
	input wire logic        rst,
	input wire logic [7:0]  addr,
	input wire logic [31:0] wdata,
	input wire logic        wr,
	input wire logic        rd,
	input wire logic [31:0] rdata,
	input wire logic        serial_out_pin,
	input wire logic        irq
);
	logic [2:0]        ctl;
	logic [STAT_W-1:0] msk;

	// Mirrors of power, enables and mask as software wrote them
	always_ff @(posedge clk) begin
		if (rst) begin
			ctl <= 3'h0;
			msk <= MASK_RST;
		end else if (wr && addr == ADDR_CTRL) begin
			ctl <= wdata[2:0];
		end else if (wr && addr == ADDR_MASK) begin
			msk <= wdata[STAT_W-1:0];
		end
	end

	default clocking @(posedge clk); endclocking
	default disable iff (rst);

	a_rdata_idle: assert property (!$past(rd) |-> rdata == 32'h0)
		else $error("rdata not idle");
	a_ctrl_echo: assert property ($past(rd)
		&& $past(addr) == ADDR_CTRL
		|-> rdata[2:0] == $past(ctl)) else $error("ctrl readback");
	a_off_idle: assert property (!ctl[0] && !$past(ctl[0])
		|-> serial_out_pin) else $error("output not idle");
	a_off_quiet: assert property (!ctl[0] && !$past(ctl[0])
		&& !$past(ctl[0], 2) |-> !irq) else $error("irq while off");
	a_bit_hold: assert property ($fell(serial_out_pin)
		|-> (!serial_out_pin || !ctl[0])[*8]) else $error("short bit");
	a_tx_gate: assert property ($fell(serial_out_pin)
		|-> ctl[0] && ctl[1]) else $error("start without enable");
	// The mask and irq registers update on the same edge, so both are
	// compared as sampled at one edge
	a_mask_gate: assert property (msk == '0 |-> !irq)
		else $error("masked irq");

	c_tx_start: cover property ($fell(serial_out_pin));
	c_irq: cover property ($rose(irq));
	c_rx_read: cover property ($past(rd) && $past(addr) == ADDR_RX);
endmodule
bind uae_top uae_props chk_i (.clk(clk), .rst(rst), .addr(addr),
	.wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
	.serial_out_pin(serial_out_pin), .irq(irq));
`default_nettype wire

// file: uae_remote.sv
`timescale 1ns/100ps
`default_nettype none
module uae_remote #(
	parameter int BIT_CLKS = 32
) (
	input  wire logic       clk,
	input  wire logic       line_in,
	output var  logic       line_out,
	output var  logic [7:0] got,
	output var  int         n_got
);
	// Idle high, so power and receive enable start nothing
	initial begin
		line_out = 1'b1;
	end

	task automatic send(input logic [7:0] b);
		logic [9:0] f;
		f = {1'b1, b, 1'b0};
		for (int i = 0; i < 10; i++) begin
			@(posedge clk);
			line_out <= f[i];
			repeat (BIT_CLKS - 1) @(posedge clk);
		end
	endtask

	// Samples mid-bit; the stop level is not judged
	initial begin
		got = 8'h00;
		n_got = 0;
		forever begin
			@(negedge line_in);
			repeat (BIT_CLKS / 2) @(posedge clk);
			for (int i = 0; i < 8; i++) begin
				repeat (BIT_CLKS) @(posedge clk);
				got[i] = line_in;
			end
			repeat (BIT_CLKS) @(posedge clk);
			n_got++;
		end
	end
endmodule
`default_nettype wire

// file: uae_top_tb.sv
`timescale 1ns/100ps
`default_nettype none
module uae_top_tb;
	import uae_pkg::*;
	logic        clk = 1'b0;
	logic        clk_run = 1'b1;
	logic        rst = 1'b1;
	logic [7:0]  addr = 8'h00;
	logic [31:0] wdata = 32'h0;
	logic        wr = 1'b0;
	logic        rd = 1'b0;
	logic [31:0] rdata;
	logic        rx_line;
	logic        tx_line;
	logic        irq;
	logic [7:0]  got;
	int          n_got;
	int          n_fail = 0;
	int          num_checks = 0;
	int          cycles = 0;

	always #2.5 clk = clk_run ? ~clk : clk;

	uae_top dut (.clk(clk), .rst(rst), .addr(addr), .wdata(wdata),
		.wr(wr), .rd(rd), .rdata(rdata), .serial_in_pin(rx_line),
		.serial_out_pin(tx_line), .irq(irq));
	uae_remote #(.BIT_CLKS(32)) remote (.clk(clk), .line_in(tx_line),
		.line_out(rx_line), .got(got), .n_got(n_got));

	////////////////////////////////////////////////////////////////////
	task automatic stop_test;
		if (n_fail == 0 && num_checks > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask

	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		num_checks++;
		if (g !== e) begin
			n_fail++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask

	task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
	endtask

	task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
		@(posedge clk);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		#1 chk(rdata, e);
	endtask

	task automatic wait_irq(input int lim);
		for (int i = 0; i < lim && irq !== 1'b1; i++) begin
			@(posedge clk);
			#1;
		end
		chk({31'h0, irq}, 32'h1);
	endtask

	always @(posedge clk) begin
		cycles <= cycles + 1;
		if (cycles == 4000) begin
			n_fail++;
			stop_test;
		end
	end

	////////////////////////////////////////////////////////////////////
	initial begin
		repeat (5) @(posedge clk);
		rst <= 1'b0;
		rd_chk(ADDR_CTRL, 32'h0);
		rd_chk(ADDR_BAUD, 32'(BAUD_DIV_RST));
		rd_chk(ADDR_MASK, 32'(MASK_RST));
		rd_chk(ADDR_STAT, 32'h0);
		rd_chk(8'h20, 32'h0);
		// Divisor 1 keeps a frame at 320 clocks
		wr_reg(ADDR_BAUD, 32'h1);
		wr_reg(ADDR_MASK, 32'h3);
		wr_reg(ADDR_CTRL, 32'h1);
		wr_reg(ADDR_CTRL, 32'h3);
		repeat (4) @(posedge clk);
		wr_reg(ADDR_TX, 32'h55);
		rd_chk(ADDR_CTRL, 32'hb);
		wait_irq(400);
		chk({24'h0, got}, 32'h55);
		chk(n_got, 32'h1);
		rd_chk(ADDR_STAT, 32'h1);
		wr_reg(ADDR_STAT, 32'h1);
		rd_chk(ADDR_STAT, 32'h0);
		wr_reg(ADDR_TX, 32'ha6);
		wait_irq(400);
		chk({24'h0, got}, 32'ha6);
		chk(n_got, 32'h2);
		wr_reg(ADDR_CTRL, 32'h1);
		wr_reg(ADDR_STAT, 32'h1);
		wr_reg(ADDR_CTRL, 32'h5);
		remote.send(8'ha3);
		wait_irq(100);
		rd_chk(ADDR_RX, 32'ha3);
		rd_chk(ADDR_STAT, 32'h2);
		// A masked status bit must not raise the interrupt
		wr_reg(ADDR_MASK, 32'h0);
		rd_chk(ADDR_STAT, 32'h2);
		chk({31'h0, irq}, 32'h0);
		wr_reg(ADDR_MASK, 32'h3);
		// Power drops in mid-frame with a status bit still pending
		fork
			remote.send(8'h3c);
		join_none
		repeat (100) @(posedge clk);
		rd_chk(ADDR_CTRL, 32'h15);
		wr_reg(ADDR_CTRL, 32'h1);
		wr_reg(ADDR_CTRL, 32'h0);
		repeat (3) @(posedge clk);
		rd_chk(ADDR_CTRL, 32'h0);
		rd_chk(ADDR_STAT, 32'h0);
		chk({30'h0, irq, tx_line}, 32'h1);
		repeat (300) @(posedge clk);
		wr_reg(ADDR_CTRL, 32'h1);
		wr_reg(ADDR_CTRL, 32'h3);
		wr_reg(ADDR_CTRL, 32'h1);
		repeat (4) @(posedge clk);
		wr_reg(ADDR_CTRL, 32'h3);
		repeat (4) @(posedge clk);
		wr_reg(ADDR_TX, 32'h0f);
		repeat (10) @(posedge clk);
		#1;
		chk({31'h0, tx_line}, 32'h0);
		clk_run = 1'b0;
		#200;
		chk({31'h0, tx_line}, 32'h0);
		clk_run = 1'b1;
		rd_chk(ADDR_CTRL, 32'hb);
		wr_reg(ADDR_CTRL, 32'h0);
		rd_chk(ADDR_CTRL, 32'h0);
		stop_test;
	end
endmodule
`default_nettype wire
